// file: design/rtc_alarm_status_irq.sv
// Calendar alarm compare, sticky event flags, interrupt mask and validity flags behind APB.
`timescale 1ns/1ps

module rtc_alarm_status_irq (
   // Clock and reset
   input  wire logic                           clk,
   input  wire logic                           rst_n,
   // APB slave
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [7:0]                     paddr,
   input  wire logic [31:0]                    pwdata,
   output logic                                pready,
   output logic                                pslverr,
   output logic [31:0]                         prdata,
   // Counter side
   input  wire rtc_status_pkg::counter_events_t events,
   input  wire rtc_status_pkg::calendar_now_t  cal_now,
   input  wire logic                           time_alarm_match,
   input  wire logic                           time_stopped,
   input  wire logic                           calendar_stopped,
   input  wire logic [3:0]                     bad_entry,
   output logic                                time_stop_request,
   output logic                                calendar_stop_request,
   output logic [1:0]                          time_event_select,
   output logic [1:0]                          calendar_event_select,
   // Interrupt
   output logic                                irq
);
   localparam int NF = rtc_status_pkg::NUM_FLAGS;

   logic [31:0]   cal_alarm_r;
   logic [NF-1:0] status_r;
   logic [NF-1:0] mask_r;
   logic [3:0]    valid_r;
   logic [31:0]   mode_r;
   logic          wr_en;
   logic          rd_en;
   logic          addr_ok;
   logic          date_ok;
   logic          month_ok;
   logic          alarm_hit;
   logic          alarm_hit_r;
   logic          time_ev;
   logic          cal_ev;
   logic [NF-1:0] set_vec;
   logic [NF-1:0] clr_vec;
   logic [3:0]    car_bad;

   // Zero-wait slave: every access completes in its first access cycle.
   assign pready  = 1'b1;
   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && penable && !pwrite;

   always_comb begin
      case (paddr)
         rtc_status_pkg::OFF_CAL_ALARM, rtc_status_pkg::OFF_STATUS,
         rtc_status_pkg::OFF_CLEAR, rtc_status_pkg::OFF_IRQ_EN,
         rtc_status_pkg::OFF_IRQ_DIS, rtc_status_pkg::OFF_IRQ_MASK,
         rtc_status_pkg::OFF_VALIDITY, rtc_status_pkg::OFF_MODE,
         rtc_status_pkg::OFF_ENTRY_BAD: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !addr_ok;

   // Calendar alarm register; reserved bits are never stored.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cal_alarm_r <= rtc_status_pkg::CAR_RESET;
      end else if (wr_en && paddr == rtc_status_pkg::OFF_CAL_ALARM) begin
         cal_alarm_r <= pwdata & rtc_status_pkg::CAR_WMASK;
      end
   end

   // Mode register holds stop requests and event selects.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mode_r <= 32'h00000000;
      end else if (wr_en && paddr == rtc_status_pkg::OFF_MODE) begin
         mode_r <= pwdata & 32'h00030303;
      end
   end
   assign time_stop_request     = mode_r[rtc_status_pkg::MODE_TSTOP];
   assign calendar_stop_request = mode_r[rtc_status_pkg::MODE_CSTOP];
   assign time_event_select     = mode_r[rtc_status_pkg::MODE_TEV_LSB +: 2];
   assign calendar_event_select = mode_r[rtc_status_pkg::MODE_CEV_LSB +: 2];

   assign month_ok = !cal_alarm_r[rtc_status_pkg::CAR_MONTH_EN] ||
                     cal_alarm_r[rtc_status_pkg::CAR_MONTH_LSB +: 5] == cal_now.month;
   assign date_ok  = !cal_alarm_r[rtc_status_pkg::CAR_DATE_EN] ||
                     cal_alarm_r[rtc_status_pkg::CAR_DATE_LSB +: 6] == cal_now.date;
   assign alarm_hit = time_alarm_match && month_ok && date_ok;

   // The alarm flag is set on the rising edge of a match so a cleared flag
   // does not reassert for the whole matching second.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         alarm_hit_r <= 1'b0;
      end else begin
         alarm_hit_r <= alarm_hit;
      end
   end

   always_comb begin
      case (time_event_select)
         rtc_status_pkg::TEV_MINUTE:   time_ev = events.minute;
         rtc_status_pkg::TEV_HOUR:     time_ev = events.hour;
         rtc_status_pkg::TEV_MIDNIGHT: time_ev = events.midnight;
         rtc_status_pkg::TEV_NOON:     time_ev = events.noon;
         default:                      time_ev = 1'b0;
      endcase
   end

   always_comb begin
      case (calendar_event_select)
         rtc_status_pkg::CEV_WEEK:  cal_ev = events.week;
         rtc_status_pkg::CEV_MONTH: cal_ev = events.month;
         rtc_status_pkg::CEV_YEAR:  cal_ev = events.year;
         default:                   cal_ev = 1'b0;
      endcase
   end

   always_comb begin
      set_vec = '0;
      set_vec[rtc_status_pkg::BIT_ACK]   = (time_stop_request || calendar_stop_request) &&
                                           (!time_stop_request || time_stopped) &&
                                           (!calendar_stop_request || calendar_stopped);
      set_vec[rtc_status_pkg::BIT_ALARM] = alarm_hit && !alarm_hit_r;
      set_vec[rtc_status_pkg::BIT_SEC]   = events.second;
      set_vec[rtc_status_pkg::BIT_TIME_EVENT_FLAG] = time_ev;
      set_vec[rtc_status_pkg::BIT_CALENDAR_EVENT_FLAG] = cal_ev;
   end

   assign clr_vec = (wr_en && paddr == rtc_status_pkg::OFF_CLEAR) ? pwdata[NF-1:0] : '0;

   // A set arriving with its clear wins, so no event is lost.
   generate
      for (genvar i = 0; i < NF; i++) begin : g_flag
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               status_r[i] <= 1'b0;
            end else if (set_vec[i]) begin
               status_r[i] <= 1'b1;
            end else if (clr_vec[i]) begin
               status_r[i] <= 1'b0;
            end
         end

         always_ff @(posedge clk) begin
            if (!rst_n) begin
               mask_r[i] <= 1'b0;
            end else if (wr_en && paddr == rtc_status_pkg::OFF_IRQ_EN && pwdata[i]) begin
               mask_r[i] <= 1'b1;
            end else if (wr_en && paddr == rtc_status_pkg::OFF_IRQ_DIS && pwdata[i]) begin
               mask_r[i] <= 1'b0;
            end
         end
      end
   endgenerate

   assign irq = |(status_r & mask_r);

   // Calendar alarm contents checked here; the other three come from the
   // register checkers of the counter block on bad_entry.
   always_comb begin
      car_bad = 4'h0;
      // A disabled field is not checked, so the all-zero reset contents read as valid.
      if (cal_alarm_r[rtc_status_pkg::CAR_MONTH_EN] &&
          (cal_alarm_r[rtc_status_pkg::CAR_MONTH_LSB +: 4] > 4'h9 ||
           cal_alarm_r[rtc_status_pkg::CAR_MONTH_LSB +: 5] == 5'h00 ||
           cal_alarm_r[rtc_status_pkg::CAR_MONTH_LSB +: 5] > 5'h12)) begin
         car_bad[3] = 1'b1;
      end
      if (cal_alarm_r[rtc_status_pkg::CAR_DATE_EN] &&
          (cal_alarm_r[rtc_status_pkg::CAR_DATE_LSB +: 4] > 4'h9 ||
           cal_alarm_r[rtc_status_pkg::CAR_DATE_LSB +: 6] == 6'h00 ||
           cal_alarm_r[rtc_status_pkg::CAR_DATE_LSB +: 6] > 6'h31)) begin
         car_bad[3] = 1'b1;
      end
   end

   // A flag sets the cycle after bad contents are seen and drops the cycle
   // after its source, bad_entry or the alarm check, stops reporting them.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         valid_r <= 4'h0;
      end else begin
         valid_r[2:0] <= (valid_r[2:0] & bad_entry[2:0]) | bad_entry[2:0];
         valid_r[3]   <= car_bad[3] | bad_entry[3];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            rtc_status_pkg::OFF_CAL_ALARM: prdata <= cal_alarm_r;
            rtc_status_pkg::OFF_STATUS:    prdata <= {27'h0, status_r};
            rtc_status_pkg::OFF_IRQ_MASK:  prdata <= {27'h0, mask_r};
            rtc_status_pkg::OFF_VALIDITY:  prdata <= {28'h0, valid_r};
            rtc_status_pkg::OFF_MODE:      prdata <= mode_r;
            rtc_status_pkg::OFF_ENTRY_BAD: prdata <= {28'h0, bad_entry};
            default:                       prdata <= 32'h00000000;
         endcase
      end
   end

   property p_flag_set;
      @(posedge clk) disable iff (!rst_n)
         events.second |=> status_r[rtc_status_pkg::BIT_SEC];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("second flag not set");

   property p_clear;
      @(posedge clk) disable iff (!rst_n)
         (wr_en && paddr == rtc_status_pkg::OFF_CLEAR && pwdata[rtc_status_pkg::BIT_TIME_EVENT_FLAG]
          && !time_ev) |=> !status_r[rtc_status_pkg::BIT_TIME_EVENT_FLAG];
   endproperty
   a_clear: assert property (p_clear) else $error("time flag not cleared");

   property p_sticky;
      @(posedge clk) disable iff (!rst_n)
         (status_r[rtc_status_pkg::BIT_ALARM] && !(wr_en && paddr == rtc_status_pkg::OFF_CLEAR))
         |=> status_r[rtc_status_pkg::BIT_ALARM];
   endproperty
   a_sticky: assert property (p_sticky) else $error("alarm flag dropped");

   property p_enable;
      @(posedge clk) disable iff (!rst_n)
         (wr_en && paddr == rtc_status_pkg::OFF_IRQ_EN && pwdata[0]) |=> mask_r[0];
   endproperty
   a_enable: assert property (p_enable) else $error("mask not set");

   property p_disable;
      @(posedge clk) disable iff (!rst_n)
         (wr_en && paddr == rtc_status_pkg::OFF_IRQ_DIS && pwdata[1]) |=> !mask_r[1];
   endproperty
   a_disable: assert property (p_disable) else $error("mask not cleared");

   property p_irq;
      @(posedge clk) disable iff (!rst_n)
         (events.second && mask_r[rtc_status_pkg::BIT_SEC]
          && !(wr_en && paddr == rtc_status_pkg::OFF_IRQ_DIS)) |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch");

   property p_month_ignored;
      @(posedge clk) disable iff (!rst_n)
         (!cal_alarm_r[rtc_status_pkg::CAR_MONTH_EN] && cal_alarm_r[rtc_status_pkg::CAR_DATE_EN]
          && cal_alarm_r[rtc_status_pkg::CAR_DATE_LSB +: 6] == cal_now.date
          && time_alarm_match && !alarm_hit_r) |=> status_r[rtc_status_pkg::BIT_ALARM];
   endproperty
   a_month_ignored: assert property (p_month_ignored) else $error("alarm missed");

   property p_date_block;
      @(posedge clk) disable iff (!rst_n)
         (cal_alarm_r[rtc_status_pkg::CAR_DATE_EN] &&
          cal_alarm_r[rtc_status_pkg::CAR_DATE_LSB +: 6] != cal_now.date) |-> !alarm_hit;
   endproperty
   a_date_block: assert property (p_date_block) else $error("date mismatch hit");

   property p_reset_zero;
      @(posedge clk) $rose(rst_n) |-> (status_r == '0 && mask_r == '0 && valid_r == '0);
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("flags not reset");

   // Read-only registers must shrug off bus writes to their own address; only enable, disable and clear writes and hardware events move them.
   property p_mask_ro;
      @(posedge clk) disable iff (!rst_n)
         (wr_en && paddr == rtc_status_pkg::OFF_IRQ_MASK) |=> mask_r == $past(mask_r);
   endproperty
   a_mask_ro: assert property (p_mask_ro) else $error("mask written directly");

   property p_status_ro;
      @(posedge clk) disable iff (!rst_n)
         (wr_en && paddr == rtc_status_pkg::OFF_STATUS && set_vec == '0)
         |=> status_r == $past(status_r);
   endproperty
   a_status_ro: assert property (p_status_ro) else $error("status written directly");

   property p_read_upper;
      @(posedge clk) disable iff (!rst_n)
         (rd_en && (paddr == rtc_status_pkg::OFF_STATUS ||
                    paddr == rtc_status_pkg::OFF_IRQ_MASK)) |-> prdata[31:NF] == '0;
   endproperty
   a_read_upper: assert property (p_read_upper) else $error("upper bits read high");

   property p_month_compare;
      @(posedge clk) disable iff (!rst_n)
         (cal_alarm_r[rtc_status_pkg::CAR_MONTH_EN] &&
          cal_alarm_r[rtc_status_pkg::CAR_MONTH_LSB +: 5] != cal_now.month) |-> !alarm_hit;
   endproperty
   a_month_compare: assert property (p_month_compare) else $error("month mismatch hit");

   property p_full_match;
      @(posedge clk) disable iff (!rst_n)
         (cal_alarm_r[rtc_status_pkg::CAR_DATE_EN] &&
          cal_alarm_r[rtc_status_pkg::CAR_MONTH_EN] &&
          cal_alarm_r[rtc_status_pkg::CAR_DATE_LSB +: 6] == cal_now.date &&
          cal_alarm_r[rtc_status_pkg::CAR_MONTH_LSB +: 5] == cal_now.month &&
          time_alarm_match && !alarm_hit_r) |=> status_r[rtc_status_pkg::BIT_ALARM];
   endproperty
   a_full_match: assert property (p_full_match) else $error("date match missed");

   property p_ack_set;
      @(posedge clk) disable iff (!rst_n)
         (time_stop_request && calendar_stop_request && time_stopped && calendar_stopped)
         |=> status_r[rtc_status_pkg::BIT_ACK];
   endproperty
   a_ack_set: assert property (p_ack_set) else $error("update ack not set");

   property p_ack_idle;
      @(posedge clk) disable iff (!rst_n)
         (!time_stop_request && !calendar_stop_request && !status_r[rtc_status_pkg::BIT_ACK])
         |=> !status_r[rtc_status_pkg::BIT_ACK];
   endproperty
   a_ack_idle: assert property (p_ack_idle) else $error("update ack without stop");

   property p_time_event;
      @(posedge clk) disable iff (!rst_n)
         (time_event_select == rtc_status_pkg::TEV_HOUR && events.hour)
         |=> status_r[rtc_status_pkg::BIT_TIME_EVENT_FLAG];
   endproperty
   a_time_event: assert property (p_time_event) else $error("hour event lost");

   property p_noon_only;
      @(posedge clk) disable iff (!rst_n)
         (time_event_select == rtc_status_pkg::TEV_NOON && !events.noon &&
          !status_r[rtc_status_pkg::BIT_TIME_EVENT_FLAG]) |=> !status_r[rtc_status_pkg::BIT_TIME_EVENT_FLAG];
   endproperty
   a_noon_only: assert property (p_noon_only) else $error("wrong time event");

   property p_cal_event;
      @(posedge clk) disable iff (!rst_n)
         (calendar_event_select == rtc_status_pkg::CEV_MONTH && events.month)
         |=> status_r[rtc_status_pkg::BIT_CALENDAR_EVENT_FLAG];
   endproperty
   a_cal_event: assert property (p_cal_event) else $error("month event lost");

   property p_cal_reserved;
      @(posedge clk) disable iff (!rst_n)
         (calendar_event_select == 2'h3 && !status_r[rtc_status_pkg::BIT_CALENDAR_EVENT_FLAG])
         |=> !status_r[rtc_status_pkg::BIT_CALENDAR_EVENT_FLAG];
   endproperty
   a_cal_reserved: assert property (p_cal_reserved) else $error("bad calendar event");

   property p_valid_follow;
      @(posedge clk) disable iff (!rst_n)
         bad_entry[0] |=> valid_r[0];
   endproperty
   a_valid_follow: assert property (p_valid_follow) else $error("bad time unflagged");

   property p_stop_req;
      @(posedge clk) disable iff (!rst_n)
         (wr_en && paddr == rtc_status_pkg::OFF_MODE && pwdata[rtc_status_pkg::MODE_TSTOP])
         |=> time_stop_request;
   endproperty
   a_stop_req: assert property (p_stop_req) else $error("time stop not requested");
endmodule

// file: design/rtc_status_pkg.sv
// Package with register map, field positions and carrier types of the alarm and status block.
package rtc_status_pkg;
   localparam logic [7:0] OFF_CAL_ALARM  = 8'h14;
   localparam logic [7:0] OFF_STATUS     = 8'h18;
   localparam logic [7:0] OFF_CLEAR      = 8'h1C;
   localparam logic [7:0] OFF_IRQ_EN     = 8'h20;
   localparam logic [7:0] OFF_IRQ_DIS    = 8'h24;
   localparam logic [7:0] OFF_IRQ_MASK   = 8'h28;
   localparam logic [7:0] OFF_VALIDITY   = 8'h2C;
   localparam logic [7:0] OFF_MODE       = 8'h30;
   localparam logic [7:0] OFF_ENTRY_BAD  = 8'h34;

   localparam int NUM_FLAGS   = 5;
   localparam int BIT_ACK     = 0;
   localparam int BIT_ALARM   = 1;
   localparam int BIT_SEC     = 2;
   localparam int BIT_TIME_EVENT_FLAG   = 3;
   localparam int BIT_CALENDAR_EVENT_FLAG   = 4;

   localparam int CAR_DATE_LSB  = 24;
   localparam int CAR_DATE_EN   = 31;
   localparam int CAR_MONTH_LSB = 16;
   localparam int CAR_MONTH_EN  = 23;
   localparam logic [31:0] CAR_WMASK = 32'hBF9F0000;
   localparam logic [31:0] CAR_RESET = 32'h00000000;

   localparam int MODE_TSTOP  = 0;
   localparam int MODE_CSTOP  = 1;
   localparam int MODE_TEV_LSB = 8;
   localparam int MODE_CEV_LSB = 16;

   localparam logic [1:0] TEV_MINUTE   = 2'h0;
   localparam logic [1:0] TEV_HOUR     = 2'h1;
   localparam logic [1:0] TEV_MIDNIGHT = 2'h2;
   localparam logic [1:0] TEV_NOON     = 2'h3;
   localparam logic [1:0] CEV_WEEK     = 2'h0;
   localparam logic [1:0] CEV_MONTH    = 2'h1;
   localparam logic [1:0] CEV_YEAR     = 2'h2;

   typedef struct packed {
      logic second;
      logic minute;
      logic hour;
      logic midnight;
      logic noon;
      logic week;
      logic month;
      logic year;
   } counter_events_t;

   typedef struct packed {
      logic [5:0] date;
      logic [4:0] month;
   } calendar_now_t;
endpackage

// file: dv/rtc_alarm_status_irq_tb_top.sv
// Self-checking testbench for the alarm, status, mask and validity block.
`timescale 1ns/1ps
module rtc_alarm_status_irq_tb_top;
   localparam logic [7:0] A_CAR  = rtc_status_pkg::OFF_CAL_ALARM;
   localparam logic [7:0] A_ST   = rtc_status_pkg::OFF_STATUS;
   localparam logic [7:0] A_CLR  = rtc_status_pkg::OFF_CLEAR;
   localparam logic [7:0] A_IEN  = rtc_status_pkg::OFF_IRQ_EN;
   localparam logic [7:0] A_IDS  = rtc_status_pkg::OFF_IRQ_DIS;
   localparam logic [7:0] A_IMK  = rtc_status_pkg::OFF_IRQ_MASK;
   localparam logic [7:0] A_VAL  = rtc_status_pkg::OFF_VALIDITY;
   localparam logic [7:0] A_MODE = rtc_status_pkg::OFF_MODE;

   logic                            clk = 1'b0;
   logic                            rst_n = 1'b0;
   logic                            psel = 1'b0;
   logic                            penable = 1'b0;
   logic                            pwrite = 1'b0;
   logic [7:0]                      paddr = 8'h00;
   logic [31:0]                     pwdata = 32'h0;
   logic                            pready;
   logic                            pslverr;
   logic [31:0]                     prdata;
   rtc_status_pkg::counter_events_t events = 8'h00;
   rtc_status_pkg::calendar_now_t   cal_now = 11'h000;
   logic                            time_alarm_match = 1'b0;
   logic                            time_stopped = 1'b0;
   logic                            calendar_stopped = 1'b0;
   logic [3:0]                      bad_entry = 4'h0;
   logic                            time_stop_request;
   logic                            calendar_stop_request;
   logic [1:0]                      time_event_select;
   logic [1:0]                      calendar_event_select;
   logic                            irq;
   int                              fails = 0;
   int                              num_checks = 0;
   logic [31:0]                     q;
   logic                            e;
   logic [7:0]                      tev[4] = '{8'h40, 8'h20, 8'h10, 8'h08};
   logic [7:0]                      cev[4] = '{8'h04, 8'h02, 8'h01, 8'h00};
   logic [31:0]                     al_car[5] = '{32'hA5920000, 32'hA5920000, 32'hA5120000,
                                                 32'hA5920000, 32'h25920000};
   logic [10:0]                     al_now[5] = '{{6'h25, 5'h12}, {6'h25, 5'h11}, {6'h25, 5'h11},
                                                 {6'h24, 5'h12}, {6'h24, 5'h12}};
   logic [31:0]                     al_exp[5] = '{32'h2, 32'h0, 32'h2, 32'h0, 32'h2};

   always #12.5 clk = ~clk;

   rtc_alarm_status_irq u_rtc_alarm_status_irq (
      .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
      .events, .cal_now, .time_alarm_match, .time_stopped, .calendar_stopped, .bad_entry,
      .time_stop_request, .calendar_stop_request, .time_event_select,
      .calendar_event_select, .irq);

   task automatic conclude();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      num_checks++;
      if (got !== ex) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, ex, got);
      end
   endtask

   // The master waits for pready with no bound of its own; only the watchdog ends a hang.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] ex, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, ex, q);
      chk({nm, " err"}, 32'h0, {31'h0, e});
   endtask

   task automatic pulse(input logic [7:0] ev);
      @(posedge clk);
      events <= ev;
      @(posedge clk);
      events <= 8'h00;
   endtask

   initial begin
      repeat (3000) @(posedge clk);
      fails++;
      conclude();
   end

   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rdc(A_CAR, 32'h0, "car reset");
      rdc(A_IMK, 32'h0, "mask reset");
      wr(A_ST, 32'hFFFFFFFF);
      wr(A_IMK, 32'hFFFFFFFF);
      wr(A_VAL, 32'hFFFFFFFF);
      rdc(A_ST, 32'h0, "status ro");
      rdc(A_IMK, 32'h0, "mask ro");
      rdc(A_VAL, 32'h0, "validity ro");
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped data", 32'h0, q);
      chk("unmapped err", 32'h1, {31'h0, e});
      $display("test reset done");
      wr(A_IEN, 32'h1F);
      rdc(A_IMK, 32'h1F, "mask set");
      wr(A_IDS, 32'h05);
      rdc(A_IMK, 32'h1A, "mask clr");
      wr(A_IEN, 32'h0);
      rdc(A_IMK, 32'h1A, "mask keep");
      pulse(8'h80);
      rdc(A_ST, 32'h4, "second flag");
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(A_CLR, 32'h1B);
      rdc(A_ST, 32'h4, "clear zeros");
      wr(A_IEN, 32'h4);
      @(posedge clk);
      chk("irq on", 32'h1, {31'h0, irq});
      wr(A_IDS, 32'h4);
      @(posedge clk);
      chk("irq off", 32'h0, {31'h0, irq});
      wr(A_IEN, 32'h4);
      wr(A_CLR, 32'h4);
      @(posedge clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      rdc(A_ST, 32'h0, "status cleared");
      pulse(8'h80);
      @(posedge clk);
      chk("irq second", 32'h1, {31'h0, irq});
      wr(A_CLR, 32'h4);
      $display("test mask and irq done");
      for (int i = 0; i < 4; i++) begin
         wr(A_MODE, {22'h0, 2'(i), 8'h00});
         @(posedge clk);
         chk("time select", 32'(i), {30'h0, time_event_select});
         pulse(tev[(i + 1) % 4]);
         rdc(A_ST, 32'h0, "time other");
         pulse(tev[i]);
         rdc(A_ST, 32'h8, "time event");
         wr(A_CLR, 32'h8);
      end
      for (int i = 0; i < 4; i++) begin
         wr(A_MODE, {14'h0, 2'(i), 16'h0});
         @(posedge clk);
         chk("cal select", 32'(i), {30'h0, calendar_event_select});
         pulse((i == 3) ? 8'h07 : cev[(i + 1) % 3]);
         rdc(A_ST, 32'h0, "cal other");
         pulse(cev[i]);
         rdc(A_ST, (i == 3) ? 32'h0 : 32'h10, "cal event");
         wr(A_CLR, 32'h10);
      end
      $display("test event select done");
      for (int i = 0; i < 5; i++) begin
         cal_now <= al_now[i];
         wr(A_CAR, al_car[i]);
         wr(A_CLR, 32'h2);
         @(posedge clk);
         time_alarm_match <= 1'b1;
         repeat (2) @(posedge clk);
         rdc(A_ST, al_exp[i], "alarm");
         rdc(A_ST, al_exp[i], "alarm held");
         time_alarm_match <= 1'b0;
      end
      rdc(A_CAR, al_car[4], "car readback");
      $display("test alarm done");
      wr(A_CLR, 32'h1F);
      wr(A_MODE, 32'h3);
      @(posedge clk);
      chk("stop req", 32'h3, {30'h0, time_stop_request, calendar_stop_request});
      rdc(A_MODE, 32'h3, "mode readback");
      time_stopped <= 1'b1;
      rdc(A_ST, 32'h0, "ack partial");
      calendar_stopped <= 1'b1;
      repeat (2) @(posedge clk);
      rdc(A_ST, 32'h1, "ack set");
      wr(A_MODE, 32'h0);
      time_stopped <= 1'b0;
      calendar_stopped <= 1'b0;
      repeat (2) @(posedge clk);
      wr(A_CLR, 32'h1);
      rdc(A_ST, 32'h0, "ack clr");
      $display("test update ack done");
      bad_entry <= 4'h5;
      rdc(A_VAL, 32'h5, "validity a");
      bad_entry <= 4'hA;
      rdc(A_VAL, 32'hA, "validity b");
      bad_entry <= 4'h0;
      wr(A_CAR, 32'h00930000);
      rdc(A_VAL, 32'h8, "bad alarm");
      wr(A_CAR, 32'h25920000);
      rdc(A_VAL, 32'h0, "alarm fixed");
      $display("test validity done");
      conclude();
   end
endmodule
